// file: modem_pkg.sv
// Package of constants and types shared by the modem serial front end.
package modem_pkg;

    // Clock rate of i_mclk in hertz.
    localparam int CLK_HZ = 10_000_000;
    // Default serial rate in baud.
    localparam int BAUD_RATE = 9600;
    // Clock cycles per serial bit, rounded down.
    localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
    // Data bits in one character.
    localparam int DATA_BITS = 8;
    // Stop bits in one character.
    localparam int STOP_BITS = 1;
    // Idle level of the serial data lines.
    localparam logic IDLE_LEVEL = 1'b1;
    // Level of the start bit.
    localparam logic START_LEVEL = 1'b0;

    // Fast lamp period while unregistered, in milliseconds.
    localparam int FAST_BLINK_MS = 1000;
    // Slow lamp period once registered, in milliseconds.
    localparam int SLOW_BLINK_MS = 3000;
    // Lamp on time in each period, in milliseconds.
    localparam int LAMP_ON_MS = 64;
    // Ring indicator low time for a message, in milliseconds.
    localparam int MSG_PULSE_MS = 120;
    // Clock cycles per millisecond.
    localparam int MS_CYCLES = CLK_HZ / 1000;
    // Cycle counts derived from the times above.
    localparam int FAST_BLINK_CYCLES = FAST_BLINK_MS * MS_CYCLES;
    localparam int SLOW_BLINK_CYCLES = SLOW_BLINK_MS * MS_CYCLES;
    localparam int LAMP_ON_CYCLES = LAMP_ON_MS * MS_CYCLES;
    localparam int MSG_PULSE_CYCLES = MSG_PULSE_MS * MS_CYCLES;

    // Characters used by the command parser and the reply sequencer.
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_T = 8'h54;
    localparam logic [7:0] CH_O = 8'h4F;
    localparam logic [7:0] CH_K = 8'h4B;
    localparam logic [7:0] CH_E = 8'h45;
    localparam logic [7:0] CH_R = 8'h52;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    // Length of each result response in characters.
    localparam int REPLY_LEN = 4;
    localparam int ERR_LEN = 7;

    // Receiver states, one-hot.
    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_DATA = 4'h4,
        RX_STOP = 4'h8
    } rx_state_type;

    // Transmitter states, one-hot.
    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_START = 4'h2,
        TX_DATA = 4'h4,
        TX_STOP = 4'h8
    } tx_state_type;

    // Parser states, one-hot.
    typedef enum logic [3:0] {
        P_WAIT_A = 4'h1,
        P_WAIT_T = 4'h2,
        P_BODY = 4'h4,
        P_WAIT_LF = 4'h8
    } parse_state_type;

endpackage

// file: byte_link_if.sv
// Interface carrying bytes between the reply sequencer and the serial transmitter.
`timescale 1ns/1ps
interface byte_link_if;
    // Byte to send.
    logic [7:0] data;
    // Byte offered.
    logic valid;
    // Transmitter accepts the byte.
    logic ready;

    // Side that offers bytes.
    modport source (output data, output valid, input ready);
    // Side that sends bytes.
    modport sink (input data, input valid, output ready);
endinterface

// file: serial_tx.sv
// Serial character transmitter with a fixed 8N1 frame.
`timescale 1ns/1ps
module serial_tx #(
    parameter int BIT_CYCLES = modem_pkg::BIT_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    byte_link_if.sink link,
    output logic o_txd
);

    ////////////////////////////////////////////////////////////////////////////////
    // State of the transmitter.
    modem_pkg::tx_state_type state_q;
    // Cycles left in the current bit.
    logic [15:0] bit_cnt_q;
    // Index of the data bit being sent.
    logic [2:0] bit_idx_q;
    // Character being shifted out.
    logic [7:0] shift_q;

    // A byte is taken only while idle.
    assign link.ready = (state_q == modem_pkg::TX_IDLE);

    ////////////////////////////////////////////////////////////////////////////////
    // Frame sequencer; the line rests high outside a frame.
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            state_q <= modem_pkg::TX_IDLE;
            bit_cnt_q <= 16'h0000;
            bit_idx_q <= 3'h0;
            shift_q <= 8'h00;
            o_txd <= modem_pkg::IDLE_LEVEL;
        end else begin
            case (state_q)
                modem_pkg::TX_IDLE: begin
                    o_txd <= modem_pkg::IDLE_LEVEL;
                    if (link.valid) begin
                        // Take the byte and drive the low start bit.
                        shift_q <= link.data;
                        o_txd <= modem_pkg::START_LEVEL;
                        bit_cnt_q <= 16'(BIT_CYCLES - 1);
                        state_q <= modem_pkg::TX_START;
                    end
                end
                modem_pkg::TX_START: begin
                    if (bit_cnt_q == 16'h0000) begin
                        // First data bit is the least significant one.
                        o_txd <= shift_q[0];
                        shift_q <= {1'b0, shift_q[7:1]};
                        bit_idx_q <= 3'h0;
                        bit_cnt_q <= 16'(BIT_CYCLES - 1);
                        state_q <= modem_pkg::TX_DATA;
                    end else begin
                        bit_cnt_q <= bit_cnt_q - 16'h0001;
                    end
                end
                modem_pkg::TX_DATA: begin
                    if (bit_cnt_q != 16'h0000) begin
                        bit_cnt_q <= bit_cnt_q - 16'h0001;
                    end else if (bit_idx_q == 3'(modem_pkg::DATA_BITS - 1)) begin
                        // All data out; send the high stop bit.
                        o_txd <= modem_pkg::IDLE_LEVEL;
                        bit_cnt_q <= 16'(BIT_CYCLES * modem_pkg::STOP_BITS - 1);
                        state_q <= modem_pkg::TX_STOP;
                    end else begin
                        o_txd <= shift_q[0];
                        shift_q <= {1'b0, shift_q[7:1]};
                        bit_idx_q <= bit_idx_q + 3'h1;
                        bit_cnt_q <= 16'(BIT_CYCLES - 1);
                    end
                end
                modem_pkg::TX_STOP: begin
                    if (bit_cnt_q == 16'h0000) begin
                        state_q <= modem_pkg::TX_IDLE;
                    end else begin
                        bit_cnt_q <= bit_cnt_q - 16'h0001;
                    end
                end
                default: begin
                    state_q <= modem_pkg::TX_IDLE;
                    o_txd <= modem_pkg::IDLE_LEVEL;
                end
            endcase
        end
    end

endmodule

// file: modem_serial_status.sv
// Serial command front end of the modem: receiver, parser, ring line and status lamp.
`timescale 1ns/1ps
module modem_serial_status #(
    parameter int BIT_CYCLES = modem_pkg::BIT_CYCLES,
    parameter int FAST_BLINK_CYCLES = modem_pkg::FAST_BLINK_CYCLES,
    parameter int SLOW_BLINK_CYCLES = modem_pkg::SLOW_BLINK_CYCLES,
    parameter int LAMP_ON_CYCLES = modem_pkg::LAMP_ON_CYCLES,
    parameter int MSG_PULSE_CYCLES = modem_pkg::MSG_PULSE_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_rxd,
    input wire logic i_responses_on,
    input wire logic i_call_ringing,
    input wire logic i_message_arrived,
    input wire logic i_registered,
    output logic o_txd,
    output logic o_ring_indicator,
    output logic o_network_status_lamp,
    output logic o_command_done
);

    ////////////////////////////////////////////////////////////////////////////////
    // Receiver state.
    modem_pkg::rx_state_type rx_state_q;
    // Cycles left in the current received bit.
    logic [15:0] rx_cnt_q;
    // Index of the data bit being received.
    logic [2:0] rx_idx_q;
    // Character being assembled.
    logic [7:0] rx_shift_q;
    // Pulse: a whole character was received.
    logic rx_valid_q;
    // Last received character.
    logic [7:0] rx_byte_q;

    // Receiver: samples each bit at its centre, LSB first.
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            rx_state_q <= modem_pkg::RX_IDLE;
            rx_cnt_q <= 16'h0000;
            rx_idx_q <= 3'h0;
            rx_shift_q <= 8'h00;
            rx_valid_q <= 1'b0;
            rx_byte_q <= 8'h00;
        end else begin
            rx_valid_q <= 1'b0;
            case (rx_state_q)
                modem_pkg::RX_IDLE: begin
                    if (i_rxd == modem_pkg::START_LEVEL) begin
                        // Wait half a bit to reach the start bit centre.
                        rx_cnt_q <= 16'(BIT_CYCLES / 2 - 1);
                        rx_state_q <= modem_pkg::RX_START;
                    end
                end
                modem_pkg::RX_START: begin
                    if (rx_cnt_q != 16'h0000) begin
                        rx_cnt_q <= rx_cnt_q - 16'h0001;
                    end else if (i_rxd == modem_pkg::START_LEVEL) begin
                        rx_cnt_q <= 16'(BIT_CYCLES - 1);
                        rx_idx_q <= 3'h0;
                        rx_state_q <= modem_pkg::RX_DATA;
                    end else begin
                        // A glitch, not a start bit.
                        rx_state_q <= modem_pkg::RX_IDLE;
                    end
                end
                modem_pkg::RX_DATA: begin
                    if (rx_cnt_q != 16'h0000) begin
                        rx_cnt_q <= rx_cnt_q - 16'h0001;
                    end else begin
                        rx_shift_q <= {i_rxd, rx_shift_q[7:1]};
                        rx_cnt_q <= 16'(BIT_CYCLES - 1);
                        rx_idx_q <= rx_idx_q + 3'h1;
                        if (rx_idx_q == 3'(modem_pkg::DATA_BITS - 1)) begin
                            rx_state_q <= modem_pkg::RX_STOP;
                        end
                    end
                end
                modem_pkg::RX_STOP: begin
                    if (rx_cnt_q != 16'h0000) begin
                        rx_cnt_q <= rx_cnt_q - 16'h0001;
                    end else begin
                        // Store the character; flag it valid only if the stop bit is high.
                        rx_valid_q <= (i_rxd == modem_pkg::IDLE_LEVEL);
                        rx_byte_q <= rx_shift_q;
                        rx_state_q <= modem_pkg::RX_IDLE;
                    end
                end
                default: begin
                    rx_state_q <= modem_pkg::RX_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Parser state.
    modem_pkg::parse_state_type p_state_q;
    // Characters received after the attention prefix.
    logic [3:0] body_len_q;
    // Pulse: a complete command line was received.
    logic line_done;
    // Result of that line: plain attention is OK, anything else is an error.
    logic line_ok;

    assign line_done = rx_valid_q && (p_state_q == modem_pkg::P_WAIT_LF)
        && (rx_byte_q == modem_pkg::CH_LF);
    assign line_ok = (body_len_q == 4'h0);

    // Command parser: finds A, T, optional body, CR, LF.
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            p_state_q <= modem_pkg::P_WAIT_A;
            body_len_q <= 4'h0;
        end else if (rx_valid_q) begin
            case (p_state_q)
                modem_pkg::P_WAIT_A: begin
                    body_len_q <= 4'h0;
                    if (rx_byte_q == modem_pkg::CH_A) begin
                        p_state_q <= modem_pkg::P_WAIT_T;
                    end
                end
                modem_pkg::P_WAIT_T: begin
                    // Anything but T drops back to hunting for A.
                    p_state_q <= (rx_byte_q == modem_pkg::CH_T) ? modem_pkg::P_BODY
                        : modem_pkg::P_WAIT_A;
                end
                modem_pkg::P_BODY: begin
                    if (rx_byte_q == modem_pkg::CH_CR) begin
                        p_state_q <= modem_pkg::P_WAIT_LF;
                    end else if (body_len_q != 4'hF) begin
                        body_len_q <= body_len_q + 4'h1;
                    end
                end
                modem_pkg::P_WAIT_LF: begin
                    p_state_q <= modem_pkg::P_WAIT_A;
                end
                default: begin
                    p_state_q <= modem_pkg::P_WAIT_A;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reply sequencer state.
    logic reply_busy_q;
    logic reply_ok_q;
    logic [2:0] reply_idx_q;
    // Byte presented to the transmitter.
    logic [7:0] reply_char;
    logic [2:0] reply_last;
    byte_link_if tx_link ();

    // Reply text selection: OK or ERROR, each ended by CR LF.
    always_comb begin
        reply_char = modem_pkg::CH_LF;
        reply_last = reply_ok_q ? 3'(modem_pkg::REPLY_LEN - 1) : 3'(modem_pkg::ERR_LEN - 1);
        if (reply_ok_q) begin
            case (reply_idx_q)
                3'h0: reply_char = modem_pkg::CH_O;
                3'h1: reply_char = modem_pkg::CH_K;
                3'h2: reply_char = modem_pkg::CH_CR;
                default: reply_char = modem_pkg::CH_LF;
            endcase
        end else begin
            case (reply_idx_q)
                3'h0: reply_char = modem_pkg::CH_E;
                3'h1: reply_char = modem_pkg::CH_R;
                3'h2: reply_char = modem_pkg::CH_R;
                3'h3: reply_char = modem_pkg::CH_O;
                3'h4: reply_char = modem_pkg::CH_R;
                3'h5: reply_char = modem_pkg::CH_CR;
                default: reply_char = modem_pkg::CH_LF;
            endcase
        end
    end

    assign tx_link.data = reply_char;
    assign tx_link.valid = reply_busy_q;

    // Starts a reply after each line when responses are on and no reply is being sent.
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            reply_busy_q <= 1'b0;
            reply_ok_q <= 1'b0;
            reply_idx_q <= 3'h0;
            o_command_done <= 1'b0;
        end else begin
            // One-cycle mark that a valid command was carried out.
            o_command_done <= line_done && line_ok;
            if (!reply_busy_q) begin
                if (line_done && i_responses_on) begin
                    reply_busy_q <= 1'b1;
                    reply_ok_q <= line_ok;
                    reply_idx_q <= 3'h0;
                end
            end else if (tx_link.ready) begin
                if (reply_idx_q == reply_last) begin
                    reply_busy_q <= 1'b0;
                end else begin
                    reply_idx_q <= reply_idx_q + 3'h1;
                end
            end
        end
    end

    // Serial transmitter that frames each reply byte.
    serial_tx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_tx (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .link(tx_link.sink),
        .o_txd(o_txd)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Cycles left in a message pulse.
    logic [31:0] msg_cnt_q;

    // Ring line: low while ringing, short low pulse per message.
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            msg_cnt_q <= 32'h0000_0000;
            o_ring_indicator <= 1'b1;
        end else begin
            if (i_message_arrived) begin
                msg_cnt_q <= 32'(MSG_PULSE_CYCLES);
            end else if (msg_cnt_q != 32'h0000_0000) begin
                msg_cnt_q <= msg_cnt_q - 32'h0000_0001;
            end
            o_ring_indicator <= !(i_call_ringing || i_message_arrived
                || (msg_cnt_q > 32'h0000_0001));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Lamp period counter.
    logic [31:0] lamp_cnt_q;
    logic [31:0] lamp_period;

    assign lamp_period = i_registered ? 32'(SLOW_BLINK_CYCLES) : 32'(FAST_BLINK_CYCLES);

    // Status lamp: short flash at the start of each period.
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            lamp_cnt_q <= 32'h0000_0000;
            o_network_status_lamp <= 1'b0;
        end else begin
            if (lamp_cnt_q >= lamp_period - 32'h0000_0001) begin
                lamp_cnt_q <= 32'h0000_0000;
            end else begin
                lamp_cnt_q <= lamp_cnt_q + 32'h0000_0001;
            end
            o_network_status_lamp <= (lamp_cnt_q < 32'(LAMP_ON_CYCLES));
        end
    end

endmodule

// file: host_uart_model.sv
// Host-side UART model that sends text lines and collects the modem's replies.
`timescale 1ns/1ps
module host_uart_model #(
    parameter int BIT_CYCLES = 16
) (
    input wire logic i_mclk,
    input wire logic i_txd_seen,
    output logic o_rxd_drive
);
    // Bytes decoded from the modem's transmit line, oldest first.
    logic [7:0] rx_q[$];

    ////////////////////////////////////////////////////////////////////////////////
    // The line idles high between characters, changing only on falling edges.
    initial begin
        o_rxd_drive = modem_pkg::IDLE_LEVEL;
    end

    // One 8N1 character: low start, data least significant bit first, high stop.
    task automatic send_byte(input logic [7:0] value);
        @(negedge i_mclk);
        o_rxd_drive = modem_pkg::START_LEVEL;
        repeat (BIT_CYCLES) @(negedge i_mclk);
        for (int i = 0; i < 8; i++) begin
            o_rxd_drive = value[i];
            repeat (BIT_CYCLES) @(negedge i_mclk);
        end
        o_rxd_drive = modem_pkg::IDLE_LEVEL;
        repeat (BIT_CYCLES) @(negedge i_mclk);
    endtask

    // A command line is its text followed by carriage return and line feed.
    task automatic send_line(input string text);
        for (int i = 0; i < text.len(); i++) begin
            send_byte(8'(text[i]));
        end
        send_byte(modem_pkg::CH_CR);
        send_byte(modem_pkg::CH_LF);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Receiver samples mid-bit; a character with a low stop bit is queued as unknown.
    initial begin
        logic [7:0] shift;
        forever begin
            @(negedge i_mclk);
            if (i_txd_seen === 1'b0) begin
                repeat (BIT_CYCLES / 2) @(negedge i_mclk);
                if (i_txd_seen === 1'b0) begin
                    for (int i = 0; i < 8; i++) begin
                        repeat (BIT_CYCLES) @(negedge i_mclk);
                        shift[i] = i_txd_seen;
                    end
                    repeat (BIT_CYCLES) @(negedge i_mclk);
                    rx_q.push_back((i_txd_seen === 1'b1) ? shift : 8'hXX);
                end
            end
        end
    end
endmodule

// file: modem_serial_status_properties.sv
// Checker of the modem front end's port timing, bound to its top module.
`timescale 1ns/1ps
module modem_serial_status_properties #(
    parameter int SLOW_BLINK_CYCLES = 3000,
    parameter int LAMP_ON_CYCLES = 64,
    parameter int MSG_PULSE_CYCLES = 120
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_rxd,
    input wire logic i_responses_on,
    input wire logic i_call_ringing,
    input wire logic i_message_arrived,
    input wire logic i_registered,
    input wire logic o_txd,
    input wire logic o_ring_indicator,
    input wire logic o_network_status_lamp,
    input wire logic o_command_done
);
    // Run lengths of the lamp lit, lamp dark and message-only ring low.
    int lit_cnt_q;
    int dark_cnt_q;
    int ring_low_q;

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    ////////////////////////////////////////////////////////////////////////////////
    // Counters restart whenever the level they measure ends.
    always_ff @(posedge i_mclk) begin
        lit_cnt_q <= (!i_resetn || !o_network_status_lamp) ? 0 : lit_cnt_q + 1;
        dark_cnt_q <= (!i_resetn || o_network_status_lamp) ? 0 : dark_cnt_q + 1;
    end

    // A call holds the line low on its own, so only message lows are counted.
    always_ff @(posedge i_mclk) begin
        ring_low_q <= (!i_resetn || o_ring_indicator || i_call_ringing) ? 0 : ring_low_q + 1;
    end

    // A start bit is at least eight clocks of low on the transmit line.
    sequence start_bit_low;
        !o_txd [*8];
    endsequence

    // The message pulse holds the ring line low for a run of clocks.
    sequence msg_pulse_low;
        !o_ring_indicator [*8];
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    a_reset_idle_levels: assert property (@(posedge i_mclk) disable iff (1'b0)
        !i_resetn |=> o_txd && o_ring_indicator && !o_command_done && !o_network_status_lamp)
        else $error("outputs not idle after reset");
    a_lamp_lit_release: assert property ($rose(i_resetn) |=> o_network_status_lamp)
        else $error("lamp not lit after reset release");
    a_txd_start_bit: assert property ($fell(o_txd) |-> start_bit_low)
        else $error("transmit low shorter than a bit");
    a_reply_follows_done: assert property (
        o_command_done && i_responses_on |-> ##[0:8] !o_txd)
        else $error("no reply after command completed");
    a_done_single_pulse: assert property (o_command_done |=> !o_command_done)
        else $error("command done longer than one cycle");
    a_ring_follows_call: assert property (i_call_ringing |=> !o_ring_indicator)
        else $error("ring line high during a call");
    a_ring_release_idle: assert property (
        $rose(o_ring_indicator) |-> !$past(i_call_ringing))
        else $error("ring line released while ringing");
    a_msg_pulse_start: assert property (i_message_arrived |=> msg_pulse_low)
        else $error("message pulse too short");
    a_msg_pulse_bound: assert property (ring_low_q <= MSG_PULSE_CYCLES + 2)
        else $error("message pulse too long");
    a_lamp_lit_bound: assert property (lit_cnt_q <= LAMP_ON_CYCLES)
        else $error("lamp lit too long");
    a_lamp_dark_bound: assert property (dark_cnt_q <= SLOW_BLINK_CYCLES)
        else $error("lamp dark too long");
endmodule

bind modem_serial_status modem_serial_status_properties #(
    .SLOW_BLINK_CYCLES(SLOW_BLINK_CYCLES),
    .LAMP_ON_CYCLES(LAMP_ON_CYCLES),
    .MSG_PULSE_CYCLES(MSG_PULSE_CYCLES)
) u_modem_serial_status_properties (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_rxd(i_rxd), .i_responses_on(i_responses_on),
    .i_call_ringing(i_call_ringing), .i_message_arrived(i_message_arrived),
    .i_registered(i_registered), .o_txd(o_txd), .o_ring_indicator(o_ring_indicator),
    .o_network_status_lamp(o_network_status_lamp), .o_command_done(o_command_done)
);

// file: at_modem_serial_status_bench.sv
// Self-checking bench of the modem front end with a host UART model.
`timescale 1ns/1ps
module at_modem_serial_status_bench;
    // Shortened counts so lamp and ring timing fit in a short run.
    localparam int BIT_C = 16;
    localparam int FAST_C = 1000;
    localparam int SLOW_C = 3000;
    localparam int LIT_C = 64;
    localparam int MSG_C = 120;

    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_rxd;
    logic i_responses_on = 1'b1;
    logic i_call_ringing = 1'b0;
    logic i_message_arrived = 1'b0;
    logic i_registered = 1'b0;
    logic o_txd;
    logic o_ring_indicator;
    logic o_network_status_lamp;
    logic o_command_done;
    int mismatches = 0;
    int n_compared = 0;
    int done_n = 0;

    always #50 i_mclk = ~i_mclk;

    modem_serial_status #(.BIT_CYCLES(BIT_C), .FAST_BLINK_CYCLES(FAST_C),
        .SLOW_BLINK_CYCLES(SLOW_C), .LAMP_ON_CYCLES(LIT_C), .MSG_PULSE_CYCLES(MSG_C)
    ) u_modem_serial_status (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_rxd(i_rxd),
        .i_responses_on(i_responses_on), .i_call_ringing(i_call_ringing),
        .i_message_arrived(i_message_arrived), .i_registered(i_registered), .o_txd(o_txd),
        .o_ring_indicator(o_ring_indicator), .o_network_status_lamp(o_network_status_lamp),
        .o_command_done(o_command_done));

    host_uart_model #(.BIT_CYCLES(BIT_C)) u_host_uart_model (.i_mclk(i_mclk),
        .i_txd_seen(o_txd), .o_rxd_drive(i_rxd));

    // Completed commands are counted as they are reported.
    always @(negedge i_mclk) begin
        if (o_command_done === 1'b1) begin
            done_n <= done_n + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic fail_now(input string msg);
        $display("unexpected at %0t: %s", $time, msg);
        mismatches++;
        print_verdict();
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            $display("unexpected at %0t: %s got %b", $time, what, got);
            mismatches++;
        end
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("unexpected at %0t: reply byte %h not %h", $time, got, exp);
            mismatches++;
        end
    endtask

    task automatic check_count(input int got, input int exp, input string what);
        n_compared++;
        if (got != exp) begin
            $display("unexpected at %0t: %s %0d not %0d", $time, what, got, exp);
            mismatches++;
        end
    endtask

    // Each expected reply byte must arrive within the time of a few characters.
    task automatic expect_reply(input string text);
        int n;
        for (int i = 0; i < text.len(); i++) begin
            n = 0;
            while (u_host_uart_model.rx_q.size() == 0) begin
                @(negedge i_mclk);
                n++;
                if (n > 40 * BIT_C) fail_now("reply missing");
            end
            check_byte(u_host_uart_model.rx_q.pop_front(), 8'(text[i]));
        end
    endtask

    // Counts falling edges until the lamp shows the wanted level.
    task automatic wait_lamp(input logic lvl, output int n);
        n = 0;
        while (o_network_status_lamp !== lvl) begin
            @(negedge i_mclk);
            n++;
            if (n > 2 * SLOW_C) fail_now("lamp stuck");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Plain attention, a command with a body, then a command with replies off.
    task automatic t_commands();
        int d0;
        d0 = done_n;
        u_host_uart_model.send_line("AT");
        expect_reply("OK\015\n");
        check_count(done_n - d0, 1, "done pulses");
        u_host_uart_model.send_line("ATE");
        expect_reply("ERROR\015\n");
        check_count(done_n - d0, 1, "done pulses");
        i_responses_on = 1'b0;
        u_host_uart_model.send_line("AT");
        repeat (30 * BIT_C) @(negedge i_mclk);
        check_count(u_host_uart_model.rx_q.size(), 0, "quiet replies");
        check_bit(o_txd, 1'b1, "idle transmit");
        i_responses_on = 1'b1;
    endtask

    // Ring line follows a call, then a message gives one short low pulse.
    task automatic t_ring();
        i_call_ringing = 1'b1;
        repeat (300) @(negedge i_mclk);
        check_bit(o_ring_indicator, 1'b0, "ring during call");
        i_call_ringing = 1'b0;
        repeat (3) @(negedge i_mclk);
        check_bit(o_ring_indicator, 1'b1, "ring after call");
        i_message_arrived = 1'b1;
        @(negedge i_mclk);
        i_message_arrived = 1'b0;
        repeat (MSG_C - 20) @(negedge i_mclk);
        check_bit(o_ring_indicator, 1'b0, "ring in pulse");
        repeat (40) @(negedge i_mclk);
        check_bit(o_ring_indicator, 1'b1, "ring after pulse");
    endtask

    // Lamp period and lit time before and after registration.
    task automatic t_lamp(input logic reg_lvl, input int period);
        int lit;
        int dark;
        i_registered = reg_lvl;
        wait_lamp(1'b0, lit);
        wait_lamp(1'b1, dark);
        wait_lamp(1'b0, lit);
        wait_lamp(1'b1, dark);
        check_count(lit, LIT_C, "lamp lit");
        check_count(lit + dark, period, "lamp period");
    endtask

    initial begin
        repeat (16) @(negedge i_mclk);
        check_bit(o_txd, 1'b1, "reset transmit");
        check_bit(o_ring_indicator, 1'b1, "reset ring");
        i_resetn = 1'b1;
        repeat (16) @(negedge i_mclk);
        t_commands();
        t_ring();
        t_lamp(1'b0, FAST_C);
        t_lamp(1'b1, SLOW_C);
        print_verdict();
    end
endmodule
